//--- logic/usb_in_endpoint_control.sv
// Contract
// - Toggle alternates; writing one restarts at DATA0
// - Set stall-sent when stall answers a token
// - Stall handshake clears packet-ready
// - Stall request makes tokens get STALL
// - Flush done clears request, raises interrupt
// - Flush waits for running transaction
// - Flush drops only the older packet
// - Packet-ready clears after host acknowledges
// - Interrupt when packet-ready is cleared
// - Block FIFO writes while packet-ready set
// - Packet-ready set ignored while stall requested
// - Control register follows selected endpoint index
// - Size 64 enables two packet slots
// - Auto-set marks ready after full packet
`timescale 1ns/10ps
`include "usb_in_ep_params.svh"

module usb_in_endpoint_control #(
   parameter logic [7:0] EP_INDEX = 8'h01
) (
   // Clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        ce_in,
   // Register port
   input  wire logic [31:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // Endpoint selection
   input  wire logic [7:0]  ep_index_in,
   // Endpoint FIFO control
   input  wire logic        fifo_wr_in,
   output logic             fifo_wr_out,
   output logic             fifo_flush_out,
   // USB engine
   input  wire logic        in_token_in,
   input  wire logic        tx_ack_in,
   input  wire logic        tx_fail_in,
   output logic             send_data_out,
   output logic             send_stall_out,
   output logic             send_nak_out,
   output logic             data_pid_out,
   // Interrupt
   output logic             irq_out
);
   // ----------------------------------------------------------------
   // Functions and state
   // ----------------------------------------------------------------
   // Packet length in bytes for a size code
   function automatic logic [6:0] size_bytes(input logic [3:0] code);
      return (code == `SIZE_CODE_16) ? `BYTES_16 :
             (code == `SIZE_CODE_32) ? `BYTES_32 :
             (code == `SIZE_CODE_64) ? `BYTES_64 : `BYTES_8;
   endfunction
   // State registers
   usb_in_ep_pkg::xfer_state_t state_reg;
   usb_in_ep_pkg::xfer_state_t state_next;
   logic [1:0]          pkt_cnt_reg;
   logic [1:0]          pkt_cnt_next;
   logic [6:0]          byte_cnt_reg;
   logic                toggle_reg;
   logic                toggle_reset_reg;
   logic                stall_req_reg;
   logic                stall_sent_reg;
   logic                flush_req_reg;
   logic [`IRQ_W-1:0]   irq_status_reg;
   logic [`IRQ_W-1:0]   irq_mask_reg;
   logic                auto_set_reg;
   logic [3:0]          size_code_reg;
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic       sel_ctrl;
   logic       wr_ctrl;
   logic       wr_mask;
   logic       wr_cfg;
   logic       rd_status;
   logic [1:0] slots;
   logic       ready_bit;
   logic       fifo_accept;
   logic       manual_set;
   logic       auto_req;
   logic       pkt_add;
   logic       ack_done;
   logic       flush_do;
   logic       flush_done;
   logic       token_idle;
   logic       stall_hit;
   logic       data_hit;
   // Control register only visible for the selected endpoint
   assign sel_ctrl  = (addr_in == `CTRL_ADDR) && (ep_index_in == EP_INDEX);
   assign wr_ctrl   = wr_in && sel_ctrl;
   assign wr_mask   = wr_in && (addr_in == `IRQ_MASK_ADDR);
   assign wr_cfg    = wr_in && (addr_in == `EP_CONFIG_ADDR);
   assign rd_status = rd_in && (addr_in == `IRQ_STATUS_ADDR);
   // Two slots at the largest size
   assign slots = (size_bytes(size_code_reg) == `BYTES_64) ? `SLOTS_DUAL : `SLOTS_SINGLE;
   assign ready_bit = (pkt_cnt_reg >= slots);
   // Writes into a full queue are dropped
   assign fifo_accept = fifo_wr_in && !ready_bit;
   // Processor handoff, refused while stalling
   assign manual_set = wr_ctrl && wdata_in[`CTRL_READY_BIT] && !ready_bit &&
                       !stall_req_reg && !wdata_in[`CTRL_STALL_BIT];
   // Automatic handoff on the last byte of a full packet
   assign auto_req = auto_set_reg && fifo_accept && !stall_req_reg &&
                     ((byte_cnt_reg + 7'h01) == size_bytes(size_code_reg));
   assign pkt_add = manual_set || auto_req;
   // Transaction events
   assign token_idle = in_token_in && (state_reg == usb_in_ep_pkg::XS_IDLE);
   assign stall_hit  = token_idle && stall_req_reg;
   assign data_hit   = token_idle && !stall_req_reg && (pkt_cnt_reg != 2'h0);
   assign ack_done   = (state_reg == usb_in_ep_pkg::XS_BUSY) && tx_ack_in;
   assign flush_done = (state_reg == usb_in_ep_pkg::XS_FLUSH);
   assign flush_do   = flush_done && (pkt_cnt_reg != 2'h0);
   // ----------------------------------------------------------------
   // Transaction state machine
   // ----------------------------------------------------------------
   // Next state; a token in idle wins over a pending flush
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         usb_in_ep_pkg::XS_IDLE: begin
            if (data_hit) begin
               state_next = usb_in_ep_pkg::XS_BUSY;
            end else if (flush_req_reg && !token_idle) begin
               state_next = usb_in_ep_pkg::XS_FLUSH;
            end
         end
         usb_in_ep_pkg::XS_BUSY: begin
            if (tx_ack_in || tx_fail_in) begin // Flush held off until settled
               state_next = usb_in_ep_pkg::XS_IDLE;
            end
         end
         usb_in_ep_pkg::XS_FLUSH: begin
            state_next = usb_in_ep_pkg::XS_IDLE;
         end
         default: begin
            state_next = usb_in_ep_pkg::XS_IDLE;
         end
      endcase
   end
   // State register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= usb_in_ep_pkg::XS_IDLE;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end
   // ----------------------------------------------------------------
   // Packet queue
   // ----------------------------------------------------------------
   // Queue depth: add on handoff, drop on ack or flush
   always_comb begin
      pkt_cnt_next = pkt_cnt_reg;
      if (stall_hit) begin
         pkt_cnt_next = 2'h0;
      end else if (pkt_add && !(ack_done || flush_do)) begin
         pkt_cnt_next = pkt_cnt_reg + 2'h1;
      end else if (!pkt_add && (ack_done || flush_do)) begin
         pkt_cnt_next = pkt_cnt_reg - 2'h1;
      end
   end
   // Queue count
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pkt_cnt_reg <= 2'h0;
      end else if (ce_in) begin
         pkt_cnt_reg <= pkt_cnt_next;
      end
   end
   // Bytes loaded into the packet being filled
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         byte_cnt_reg <= 7'h00;
      end else if (ce_in) begin
         if (pkt_add) begin
            byte_cnt_reg <= 7'h00;
         end else if (fifo_accept) begin
            byte_cnt_reg <= byte_cnt_reg + 7'h01;
         end
      end
   end
   // ----------------------------------------------------------------
   // Data toggle
   // ----------------------------------------------------------------
   // Stored restart bit; held high keeps DATA0
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         toggle_reset_reg <= 1'b0;
      end else if (ce_in && wr_ctrl) begin
         toggle_reset_reg <= wdata_in[`CTRL_TOGGLE_BIT];
      end
   end
   // Flip on each acknowledged packet
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         toggle_reg <= 1'b0;
      end else if (ce_in) begin
         if (toggle_reset_reg || (wr_ctrl && wdata_in[`CTRL_TOGGLE_BIT])) begin
            toggle_reg <= 1'b0;
         end else if (ack_done) begin
            toggle_reg <= ~toggle_reg;
         end
      end
   end
   // ----------------------------------------------------------------
   // Stall and flush control
   // ----------------------------------------------------------------
   // Stall request, written by the processor only
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stall_req_reg <= 1'b0;
      end else if (ce_in && wr_ctrl) begin
         stall_req_reg <= wdata_in[`CTRL_STALL_BIT];
      end
   end
   // Stall sent: set wins over a clearing write
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stall_sent_reg <= 1'b0;
      end else if (ce_in) begin
         if (stall_hit) begin
            stall_sent_reg <= 1'b1;
         end else if (wr_ctrl && !wdata_in[`CTRL_SENT_BIT]) begin
            stall_sent_reg <= 1'b0;
         end
      end
   end
   // Flush request: a new write wins over completion
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flush_req_reg <= 1'b0;
      end else if (ce_in) begin
         if (wr_ctrl && wdata_in[`CTRL_FLUSH_BIT]) begin
            flush_req_reg <= 1'b1;
         end else if (flush_done) begin
            flush_req_reg <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Configuration and interrupts
   // ----------------------------------------------------------------
   // Auto-set and size code
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         auto_set_reg  <= 1'b0;
         size_code_reg <= `SIZE_RESET;
      end else if (ce_in && wr_cfg) begin
         auto_set_reg  <= wdata_in[`CFG_AUTO_BIT];
         size_code_reg <= wdata_in[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
      end
   end
   // Interrupt mask
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_mask_reg <= `IRQ_W'(0);
      end else if (ce_in && wr_mask) begin
         irq_mask_reg <= wdata_in[`IRQ_W-1:0];
      end
   end
   // Sticky events, cleared by read, set wins
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_status_reg <= `IRQ_W'(0);
      end else if (ce_in) begin
         irq_status_reg[`IRQ_PKT_BIT] <=
            (irq_status_reg[`IRQ_PKT_BIT] && !rd_status) ||
            ack_done || (stall_hit && (pkt_cnt_reg != 2'h0));
         irq_status_reg[`IRQ_FLUSH_BIT] <=
            (irq_status_reg[`IRQ_FLUSH_BIT] && !rd_status) || flush_done;
      end
   end
   // Level interrupt from unmasked status
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_out <= 1'b0;
      end else if (ce_in) begin
         irq_out <= |(irq_status_reg & irq_mask_reg);
      end
   end
   // ----------------------------------------------------------------
   // Outputs to FIFO and engine
   // ----------------------------------------------------------------
   // One-cycle commands; data PID held until the next data answer
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fifo_wr_out    <= 1'b0;
         fifo_flush_out <= 1'b0;
         send_data_out  <= 1'b0;
         send_stall_out <= 1'b0;
         send_nak_out   <= 1'b0;
         data_pid_out   <= 1'b0;
      end else if (ce_in) begin
         fifo_wr_out    <= fifo_accept;
         fifo_flush_out <= flush_do;
         send_data_out  <= data_hit;
         send_stall_out <= stall_hit;
         send_nak_out   <= token_idle && !stall_req_reg && (pkt_cnt_reg == 2'h0);
         if (data_hit) begin
            data_pid_out <= toggle_reg;
         end
      end
   end
   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= `REG_RESET;
      end else if (ce_in) begin
         rdata_out <= `REG_RESET;
         if (rd_in && sel_ctrl) begin // Reserved bits read zero
            rdata_out[`CTRL_TOGGLE_BIT] <= toggle_reset_reg;
            rdata_out[`CTRL_SENT_BIT]   <= stall_sent_reg;
            rdata_out[`CTRL_STALL_BIT]  <= stall_req_reg;
            rdata_out[`CTRL_FLUSH_BIT]  <= flush_req_reg;
            rdata_out[`CTRL_READY_BIT]  <= ready_bit;
         end else if (rd_status) begin
            rdata_out[`IRQ_W-1:0] <= irq_status_reg;
         end else if (rd_in && (addr_in == `IRQ_MASK_ADDR)) begin
            rdata_out[`IRQ_W-1:0] <= irq_mask_reg;
         end else if (rd_in && (addr_in == `EP_CONFIG_ADDR)) begin
            rdata_out[`CFG_AUTO_BIT] <= auto_set_reg;
            rdata_out[`CFG_SIZE_MSB:`CFG_SIZE_LSB] <= size_code_reg;
         end
      end
   end
endmodule

//--- shared/usb_in_ep_params.svh
`ifndef USB_IN_EP_PARAMS_SVH
`define USB_IN_EP_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CTRL_ADDR        32'h5200_0184
`define IRQ_STATUS_ADDR  32'h5200_01a0
`define IRQ_MASK_ADDR    32'h5200_01a4
`define EP_CONFIG_ADDR   32'h5200_01a8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_READY_BIT   0
`define CTRL_FLUSH_BIT   3
`define CTRL_STALL_BIT   4
`define CTRL_SENT_BIT    5
`define CTRL_TOGGLE_BIT  6

// ----------------------------------------------------------------
// Interrupt status and configuration fields
// ----------------------------------------------------------------
`define IRQ_PKT_BIT      0
`define IRQ_FLUSH_BIT    1
`define IRQ_W            2
`define CFG_AUTO_BIT     7
`define CFG_SIZE_MSB     3
`define CFG_SIZE_LSB     0

// ----------------------------------------------------------------
// Reset values and size codes
// ----------------------------------------------------------------
`define REG_RESET        8'h00
`define SIZE_RESET       4'h1
`define SIZE_CODE_8      4'h1
`define SIZE_CODE_16     4'h2
`define SIZE_CODE_32     4'h4
`define SIZE_CODE_64     4'h8
`define BYTES_8          7'h08
`define BYTES_16         7'h10
`define BYTES_32         7'h20
`define BYTES_64         7'h40
`define SLOTS_SINGLE     2'h1
`define SLOTS_DUAL       2'h2

`endif

//--- shared/usb_in_ep_pkg.sv
package usb_in_ep_pkg;

   // Transaction state, gray coded along idle, busy, flush
   typedef enum logic [1:0] {
      XS_IDLE  = 2'b00,
      XS_BUSY  = 2'b01,
      XS_FLUSH = 2'b11
   } xfer_state_t;

endpackage

//--- sim/usb_host_model.sv
`timescale 1ns/10ps
// ----
// Host: IN tokens, ack or timeout
// ----
module usb_host_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // Bench commands
   input  wire logic       go_in,
   input  wire logic       fail_in,
   input  wire logic [3:0] dly_in,
   // Endpoint side
   input  wire logic       send_data_in,
   output logic            token_out,
   output logic            ack_out,
   output logic            nack_out
);
   logic [3:0] wait_reg;
   // Token pulse; reply after chosen delay
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         token_out <= 1'b0;
         ack_out <= 1'b0;
         nack_out <= 1'b0;
         wait_reg <= 4'h0;
      end else begin
         token_out <= go_in;
         ack_out <= wait_reg == 4'h1 && !fail_in;
         nack_out <= wait_reg == 4'h1 && fail_in;
         if (send_data_in) wait_reg <= dly_in;
         else if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
      end
   end
endmodule

//--- sim/usb_in_endpoint_control_tb_top.sv
`timescale 1ns/10ps
`include "usb_in_ep_params.svh"
module usb_in_endpoint_control_tb_top;
   logic clk_in, nrst_in, wr_in, rd_in, fifo_wr_in, go, fail, pid, ce;
   logic [31:0] addr_in;
   logic [7:0] wdata_in, ep_index_in, rdata_out;
   logic [3:0] dly;
   logic [2:0] ans;
   logic fifo_wr_out, fifo_flush_out, in_token_in, tx_ack_in, tx_fail_in;
   logic send_data_out, send_stall_out, send_nak_out, data_pid_out, irq_out;
   int bad_count, checks, q, slots, etog, flushes, f0;
   bit tgl, stall, sent;
   usb_in_endpoint_control u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .ep_index_in(ep_index_in), .fifo_wr_in(fifo_wr_in),
      .fifo_wr_out(fifo_wr_out), .fifo_flush_out(fifo_flush_out), .in_token_in(in_token_in),
      .tx_ack_in(tx_ack_in), .tx_fail_in(tx_fail_in), .send_data_out(send_data_out),
      .send_stall_out(send_stall_out), .send_nak_out(send_nak_out),
      .data_pid_out(data_pid_out), .irq_out(irq_out));
   usb_host_model u_host (.clk_in(clk_in), .nrst_in(nrst_in), .go_in(go), .fail_in(fail),
      .dly_in(dly), .send_data_in(send_data_out), .token_out(in_token_in),
      .ack_out(tx_ack_in), .nack_out(tx_fail_in));
   // ----
   // Checking and bus tasks
   // ----
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [7:0] ectl();
      return {1'b0, tgl, sent, stall, 3'h0, q == slots};
   endfunction
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(nm, rdata_out, e);
   endtask
   task automatic fb(input logic [7:0] e);
      @(posedge clk_in);
      fifo_wr_in <= 1'b1;
      @(posedge clk_in);
      fifo_wr_in <= 1'b0;
      #1;
      chk("fifo", 8'(fifo_wr_out), e);
   endtask
   // Token and answer, order nak stall data
   task automatic tok(input logic [2:0] ea, input logic fl, input logic [3:0] d);
      @(posedge clk_in);
      fail <= fl;
      dly <= d;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      ans = 3'h0;
      for (int i = 0; i < 6 && ans == 3'h0; i++) begin
         @(posedge clk_in);
         #1;
         ans = {send_nak_out, send_stall_out, send_nak_out ? 1'b0 : send_data_out};
         pid = data_pid_out;
      end
      chk("answer", 8'(ans), 8'(ea));
   endtask
   task automatic done();
      for (int i = 0; i < 20 && !(tx_ack_in === 1'b1 || tx_fail_in === 1'b1); i++) begin
         @(posedge clk_in);
         #1;
      end
      repeat (5) @(posedge clk_in);
      #1;
   endtask
   always @(posedge clk_in) if (fifo_flush_out === 1'b1) flushes++;
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      #300000;
      bad_count++;
      end_of_test();
   end
   // ----
   // Main sequence
   // ----
   initial begin
      void'($urandom(71641));
      {nrst_in, wr_in, rd_in, fifo_wr_in, go, fail} = 6'h00;
      ce = 1'b1;
      addr_in = 32'h0;
      wdata_in = 8'h00;
      ep_index_in = 8'h01;
      dly = 4'h1;
      {bad_count, checks, q, etog, flushes, tgl, stall, sent} = 0;
      slots = 1;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(`CTRL_ADDR, 8'h00, "ctrl");
      rd(`IRQ_STATUS_ADDR, 8'h00, "status");
      rd(`IRQ_MASK_ADDR, 8'h00, "mask");
      rd(`EP_CONFIG_ADDR, 8'h01, "config");
      rd(32'h5200_0190, 8'h00, "unmapped");
      wr(`IRQ_MASK_ADDR, 8'h03);
      repeat (8) fb(8'h01);
      wr(`CTRL_ADDR, 8'h01);
      q = 1;
      rd(`CTRL_ADDR, ectl(), "ready");
      fb(8'h00);
      // Five transfers, one timeout, toggle held then released
      for (int k = 0; k < 5; k++) begin
         if (k >= 3) begin
            tgl = (k == 3);
            wr(`CTRL_ADDR, {1'b0, tgl, 6'h00});
         end
         if (q == 0) begin
            wr(`CTRL_ADDR, {1'b0, tgl, 6'h01});
            q = 1;
         end
         tok(3'b001, k == 1, 4'($urandom_range(1, 6)));
         chk("pid", 8'(pid), 8'(tgl ? 0 : etog));
         done();
         if (k != 1) begin
            q = 0;
            etog = tgl ? 0 : etog ^ 1;
         end
         chk("irq", 8'(irq_out), 8'(k != 1));
         rd(`IRQ_STATUS_ADDR, 8'(k != 1), "status");
         rd(`CTRL_ADDR, ectl(), "ctrl");
      end
      tok(3'b100, 1'b0, 4'h1);
      // Stall with a packet queued
      wr(`CTRL_ADDR, 8'h01);
      q = 1;
      wr(`CTRL_ADDR, 8'h10);
      stall = 1;
      rd(`CTRL_ADDR, ectl(), "stall req");
      tok(3'b010, 1'b0, 4'h1);
      q = 0;
      sent = 1;
      rd(`CTRL_ADDR, ectl(), "stall sent");
      rd(`IRQ_STATUS_ADDR, 8'h01, "stall drop");
      wr(`CTRL_ADDR, 8'h31);
      rd(`CTRL_ADDR, ectl(), "ready blocked");
      wr(`CTRL_ADDR, 8'h86);
      {stall, sent} = 2'b00;
      rd(`CTRL_ADDR, ectl(), "stall end");
      // Flush one packet, its interrupt masked
      wr(`IRQ_MASK_ADDR, 8'h01);
      wr(`CTRL_ADDR, 8'h01);
      f0 = flushes;
      wr(`CTRL_ADDR, 8'h08);
      repeat (5) @(posedge clk_in);
      #1;
      chk("flush", 8'(flushes - f0), 8'h01);
      chk("irq masked", 8'(irq_out), 8'h00);
      rd(`CTRL_ADDR, ectl(), "flush done");
      rd(`IRQ_STATUS_ADDR, 8'h02, "flush irq");
      wr(`IRQ_MASK_ADDR, 8'h03);
      // Two slots, flush held behind a running packet
      wr(`EP_CONFIG_ADDR, 8'h08);
      slots = 2;
      wr(`CTRL_ADDR, 8'h01);
      q = 1;
      rd(`CTRL_ADDR, ectl(), "one of two");
      wr(`CTRL_ADDR, 8'h01);
      q = 2;
      rd(`CTRL_ADDR, ectl(), "two of two");
      // Idle flush with two queued drops only the older one
      f0 = flushes;
      wr(`CTRL_ADDR, 8'h08);
      repeat (5) @(posedge clk_in);
      #1;
      chk("flush one", 8'(flushes - f0), 8'h01);
      wr(`CTRL_ADDR, 8'h01);
      q = 2;
      rd(`CTRL_ADDR, ectl(), "older gone");
      tok(3'b001, 1'b0, 4'hc);
      f0 = flushes;
      wr(`CTRL_ADDR, 8'h08);
      repeat (3) @(posedge clk_in);
      #1;
      chk("flush held", 8'(flushes - f0), 8'h00);
      done();
      q = 0;
      chk("flush after", 8'(flushes - f0), 8'h01);
      rd(`IRQ_STATUS_ADDR, 8'h03, "both irq");
      tok(3'b100, 1'b0, 4'h1);
      // Endpoint not selected
      @(posedge clk_in);
      ep_index_in <= 8'h02;
      wr(`CTRL_ADDR, 8'h10);
      rd(`CTRL_ADDR, 8'h00, "other index");
      @(posedge clk_in);
      ep_index_in <= 8'h01;
      rd(`CTRL_ADDR, ectl(), "own index");
      // Auto-set after a full packet
      wr(`EP_CONFIG_ADDR, 8'h81);
      slots = 1;
      repeat (8) fb(8'h01);
      q = 1;
      rd(`CTRL_ADDR, ectl(), "auto set");
      fb(8'h00);
      // Clock enable low freezes the registers
      @(posedge clk_in);
      ce <= 1'b0;
      wr(`CTRL_ADDR, 8'h10);
      @(posedge clk_in);
      ce <= 1'b1;
      rd(`CTRL_ADDR, ectl(), "frozen");
      end_of_test();
   end
endmodule
bind usb_in_endpoint_control usb_in_ep_checker #(.EP_INDEX(EP_INDEX)) u_chk (
   .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .ep_index_in(ep_index_in), .fifo_wr_in(fifo_wr_in), .fifo_wr_out(fifo_wr_out),
   .in_token_in(in_token_in), .send_data_out(send_data_out), .send_stall_out(send_stall_out),
   .send_nak_out(send_nak_out), .data_pid_out(data_pid_out), .irq_out(irq_out));

//--- sim/usb_in_ep_properties.sv
`timescale 1ns/10ps
`include "usb_in_ep_params.svh"
// ----
// Endpoint port checker
// ----
module usb_in_ep_checker #(
   parameter logic [7:0] EP_INDEX = 8'h01
) (
   // Clock and register port
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic        ce_in,
   input wire logic [31:0] addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  rdata_out,
   input wire logic [7:0]  ep_index_in,
   // FIFO and engine
   input wire logic        fifo_wr_in,
   input wire logic        fifo_wr_out,
   input wire logic        in_token_in,
   input wire logic        send_data_out,
   input wire logic        send_stall_out,
   input wire logic        send_nak_out,
   input wire logic        data_pid_out,
   input wire logic        irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic       stall_reg;
   logic       tgl_reg;
   logic [1:0] mask_reg;
   // Shadow of stall, toggle hold and mask bits
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stall_reg <= 1'b0;
         tgl_reg <= 1'b0;
         mask_reg <= 2'h0;
      end else if (wr_in && ce_in) begin
         if (addr_in == `CTRL_ADDR && ep_index_in == EP_INDEX) begin
            stall_reg <= wdata_in[4];
            tgl_reg <= wdata_in[6];
         end
         if (addr_in == `IRQ_MASK_ADDR) begin
            mask_reg <= wdata_in[1:0];
         end
      end
   end
   a_answer_cause: assert property ((send_data_out || send_stall_out || send_nak_out)
      |-> $past(in_token_in)) else $error("answer without token");
   a_answer_single: assert property ($onehot0({send_data_out, send_stall_out, send_nak_out}))
      else $error("several answers");
   a_stall_no_data: assert property (send_data_out |-> !$past(stall_reg))
      else $error("data sent under stall");
   a_stall_has_req: assert property (send_stall_out |-> $past(stall_reg))
      else $error("stall without request");
   a_toggle_held: assert property (send_data_out && $past(tgl_reg) |-> !data_pid_out)
      else $error("pid not held at zero");
   a_fifo_cause: assert property (fifo_wr_out |-> $past(fifo_wr_in))
      else $error("fifo write without request");
   a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside slot");
   a_reserved_zero: assert property ($past(rd_in) && $past(addr_in) == `CTRL_ADDR
      |-> rdata_out[7] == 1'b0 && rdata_out[2:1] == 2'h0) else $error("reserved bits set");
   a_irq_masked: assert property (irq_out |-> $past(mask_reg) != 2'h0)
      else $error("irq while all masked");
endmodule
